// ---- esl_pkg.sv ----
// Package with the register map, field layout and types of the external/status latch block.
package esl_pkg;

  // Register byte addresses on the Avalon-MM slave.
  localparam logic [4:0] ADDR_ICTL   = 5'h00;
  localparam logic [4:0] ADDR_SRCEN  = 5'h04;
  localparam logic [4:0] ADDR_CMD    = 5'h08;
  localparam logic [4:0] ADDR_RXCTL  = 5'h0C;
  localparam logic [4:0] ADDR_MODE   = 5'h10;
  localparam logic [4:0] ADDR_EXTOPT = 5'h14;
  localparam logic [4:0] ADDR_STATUS = 5'h18;
  localparam logic [4:0] ADDR_PEND   = 5'h1C;

  // Source bit positions, shared by the enable and live status registers.
  localparam int SRC_ZC   = 0;
  localparam int SRC_DCD  = 1;
  localparam int SRC_SYNC = 2;
  localparam int SRC_CTS  = 3;
  localparam int SRC_EOM  = 4;
  localparam int SRC_BRK  = 5;
  localparam int NSRC     = 6;

  // Field positions.
  localparam int ICTL_MASTER_EN   = 0;
  localparam int RXCTL_ENTER_SRCH = 0;
  localparam int RXCTL_RX_EN      = 1;
  localparam int MODE_LSB         = 0;
  localparam int MODE_XTAL        = 2;
  localparam int EXTOPT_AUTO_FLAG = 0;

  // Command register codes.
  localparam logic [7:0] CMD_RESET_EXT = 8'h01;
  localparam logic [7:0] CMD_RESET_EOM = 8'h02;
  localparam logic [7:0] CMD_SEND_ABRT = 8'h03;

  // Reset value of the source enables, and the count of ones that makes an abort.
  localparam logic [5:0] SRCEN_RST = 6'h3F;
  localparam logic [2:0] ABORT_ONES = 3'h7;

  typedef enum logic [1:0] {
    ESL_MODE_ASYNC,
    ESL_MODE_SYNC,
    ESL_MODE_SDLC,
    ESL_MODE_EXTSYNC
  } esl_mode_e;

  // Receiver events, each a one-cycle strobe with its qualifiers.
  typedef struct packed {
    logic bit_valid;
    logic bit_value;
    logic char_valid;
    logic null_char;
    logic framing_err;
    logic sync_match;
    logic flag_seen;
  } esl_rx_ev_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic        master_en;
    logic [5:0]  srcen;
    logic        rx_en;
    esl_mode_e   mode;
    logic        xtal;
    logic        auto_flag;
    logic        closed;
    logic [5:0]  lat;
    logic [5:0]  prev;
    logic        brk;
    logic [2:0]  ones;
    logic        end_of_message;
    logic        search;
    logic        zc;
    logic        null_keep;
  } esl_state_s;

endpackage

// ---- esl_ext_status.sv ----
// External/status interrupt latch of one serial channel, with its Avalon-MM register slave.
// Behaviour
// - Master enable bit plus six source enables.
// - Disabled source or zero count shows raw, enabled shows latch.
// - All latches close together on enabled change.
// - Pending flag set while latches closed.
// - Master enable clear keeps pending flag clear.
// - Reset-external command reopens the shared latches.
// - Status held stable during a host read.
// - Break/abort reads 0 in non-SDLC sync.
// - Async break: null plus framing error, one clears.
// - One null character kept when break ends.
// - Seven ones set abort, zero clears, forces search.
// - Both break/abort edges always close latches.
// - END_OF_MESSAGE reset command silent, CRC load sets.
// - Send abort sets END_OF_MESSAGE; async reads set.
// - Enhanced SDLC END_OF_MESSAGE means next frame writable.
// - CTS/DCD mirror pins; odd transitions keep closed.
// - Zero count live, only setting edge closes.
// - Zero count held 0 when disabled.
// - Async/external sync mirror sync pin.
// - Crystal enabled forces sync bit zero in async and external sync modes.
// - Enter-search sets, sync match clears search.
// - SDLC search on enable, command, abort; flag leaves.
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module esl_ext_status (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // Avalon-MM slave
  input  wire logic [4:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  // Line inputs and channel events
  input  wire logic               cts_in,
  input  wire logic               dcd_in,
  input  wire logic               sync_in,
  input  wire esl_pkg::esl_rx_ev_s rx_ev,
  input  wire logic               crc_to_shift,
  input  wire logic               baud_zero,
  input  wire logic               baud_reload,
  // Status toward host and channel
  output logic                    pending_flag,
  output logic                    rx_search,
  output logic                    null_char_keep,
  output logic                    tx_next_frame_ok
);

  esl_pkg::esl_state_s st_reg;
  esl_pkg::esl_state_s st_next;

  logic [5:0] raw;
  logic [5:0] status;
  logic [5:0] chg;
  logic [5:0] close_mask;
  logic       close_ev;
  logic       sync_forced;
  logic       is_async;
  logic       wr_ack;
  logic       rd_first;
  logic       cmd_reset_ext;
  logic       cmd_reset_eom;
  logic       cmd_send_abrt;
  logic       enter_search;
  logic [5:0] parity_diff;

  assign is_async    = (st_reg.mode == esl_pkg::ESL_MODE_ASYNC);
  // An illegal crystal plus external sync setting is treated like crystal in async mode.
  assign sync_forced = st_reg.xtal && (is_async || st_reg.mode == esl_pkg::ESL_MODE_EXTSYNC);

  // Raw condition of each source before the shared latch.
  always_comb
  begin
    raw                    = '0;
    raw[esl_pkg::SRC_ZC]   = st_reg.zc && st_reg.srcen[esl_pkg::SRC_ZC];
    raw[esl_pkg::SRC_DCD]  = dcd_in;
    raw[esl_pkg::SRC_CTS]  = cts_in;
    raw[esl_pkg::SRC_EOM]  = st_reg.end_of_message;
    raw[esl_pkg::SRC_BRK]  = st_reg.brk;
    if (sync_forced)
      raw[esl_pkg::SRC_SYNC] = 1'b0;
    else if (is_async || st_reg.mode == esl_pkg::ESL_MODE_EXTSYNC)
      raw[esl_pkg::SRC_SYNC] = sync_in;
    else
      raw[esl_pkg::SRC_SYNC] = st_reg.search;
  end

  // Live status: a disabled source bypasses the latch, zero count is always live.
  genvar gi;
  generate
    for (gi = 0; gi < esl_pkg::NSRC; gi++)
    begin : g_status
      if (gi == esl_pkg::SRC_ZC)
      begin : g_live
        assign status[gi] = raw[gi];
      end
      else
      begin : g_latched
        assign status[gi] = (st_reg.srcen[gi] && st_reg.closed) ? st_reg.lat[gi] : raw[gi];
      end
    end
  endgenerate

  // Edges that may close the latches; END_OF_MESSAGE and zero count close only on their setting edge.
  assign chg = raw ^ st_reg.prev;
  always_comb
  begin
    close_mask                       = 6'h3F;
    close_mask[esl_pkg::SRC_EOM]     = raw[esl_pkg::SRC_EOM];
    close_mask[esl_pkg::SRC_ZC]      = raw[esl_pkg::SRC_ZC];
    close_mask[esl_pkg::SRC_SYNC]    = !sync_forced;
  end
  assign close_ev = |(chg & st_reg.srcen & close_mask);

  // Bus decode; a write takes effect in the cycle waitrequest drops.
  assign avs_waitrequest = (avs_read || avs_write) && !st_reg.ack;
  assign wr_ack          = avs_write && st_reg.ack && avs_byteenable[0];
  assign rd_first        = avs_read && !st_reg.ack;
  assign cmd_reset_ext   = wr_ack && avs_address == esl_pkg::ADDR_CMD
                           && avs_writedata[7:0] == esl_pkg::CMD_RESET_EXT;
  assign cmd_reset_eom   = wr_ack && avs_address == esl_pkg::ADDR_CMD
                           && avs_writedata[7:0] == esl_pkg::CMD_RESET_EOM;
  assign cmd_send_abrt   = wr_ack && avs_address == esl_pkg::ADDR_CMD
                           && avs_writedata[7:0] == esl_pkg::CMD_SEND_ABRT;
  assign enter_search    = wr_ack && avs_address == esl_pkg::ADDR_RXCTL
                           && avs_writedata[esl_pkg::RXCTL_ENTER_SRCH];
  // CTS and DCD that moved an odd number of times since closing differ from their latch.
  assign parity_diff     = (raw ^ st_reg.lat) & st_reg.srcen
                           & ((6'h01 << esl_pkg::SRC_CTS) | (6'h01 << esl_pkg::SRC_DCD));

  always_comb
  begin
    st_next           = st_reg;
    st_next.ack       = (avs_read || avs_write) && !st_reg.ack;
    st_next.prev      = raw;
    st_next.null_keep = 1'b0;

    // The read word is frozen in the request's first cycle and held until it is taken.
    if (rd_first)
    begin
      st_next.rdata = '0;
      if (avs_address == esl_pkg::ADDR_ICTL)
        st_next.rdata[esl_pkg::ICTL_MASTER_EN] = st_reg.master_en;
      else if (avs_address == esl_pkg::ADDR_SRCEN)
        st_next.rdata[5:0] = st_reg.srcen;
      else if (avs_address == esl_pkg::ADDR_RXCTL)
        st_next.rdata[esl_pkg::RXCTL_RX_EN] = st_reg.rx_en;
      else if (avs_address == esl_pkg::ADDR_MODE)
        st_next.rdata[2:0] = {st_reg.xtal, st_reg.mode};
      else if (avs_address == esl_pkg::ADDR_EXTOPT)
        st_next.rdata[esl_pkg::EXTOPT_AUTO_FLAG] = st_reg.auto_flag;
      else if (avs_address == esl_pkg::ADDR_STATUS)
        st_next.rdata[5:0] = status;
      else if (avs_address == esl_pkg::ADDR_PEND)
        st_next.rdata[0] = pending_flag;
    end

    if (wr_ack)
    begin
      if (avs_address == esl_pkg::ADDR_ICTL)
        st_next.master_en = avs_writedata[esl_pkg::ICTL_MASTER_EN];
      else if (avs_address == esl_pkg::ADDR_SRCEN)
        st_next.srcen = avs_writedata[5:0];
      else if (avs_address == esl_pkg::ADDR_RXCTL)
        st_next.rx_en = avs_writedata[esl_pkg::RXCTL_RX_EN];
      else if (avs_address == esl_pkg::ADDR_MODE)
      begin
        st_next.mode = esl_pkg::esl_mode_e'(avs_writedata[esl_pkg::MODE_LSB +: 2]);
        st_next.xtal = avs_writedata[esl_pkg::MODE_XTAL];
      end
      else if (avs_address == esl_pkg::ADDR_EXTOPT)
        st_next.auto_flag = avs_writedata[esl_pkg::EXTOPT_AUTO_FLAG];
    end

    // Break in async mode, abort in SDLC, constant zero in other sync modes.
    if (is_async)
    begin
      st_next.ones = '0;
      if (rx_ev.char_valid && rx_ev.null_char && rx_ev.framing_err)
        st_next.brk = 1'b1;
      else if (rx_ev.bit_valid && rx_ev.bit_value)
        st_next.brk = 1'b0;
    end
    else if (st_reg.mode == esl_pkg::ESL_MODE_SDLC)
    begin
      if (rx_ev.bit_valid && rx_ev.bit_value)
      begin
        if (st_reg.ones != esl_pkg::ABORT_ONES)
          st_next.ones = st_reg.ones + 3'h1;
        if (st_reg.ones == esl_pkg::ABORT_ONES - 3'h1 || st_reg.ones == esl_pkg::ABORT_ONES)
          st_next.brk = 1'b1;
      end
      else if (rx_ev.bit_valid)
      begin
        st_next.ones = '0;
        st_next.brk  = 1'b0;
      end
    end
    else
    begin
      st_next.ones = '0;
      st_next.brk  = 1'b0;
    end
    // The receiver leaves one null in its FIFO when the break ends.
    st_next.null_keep = is_async && st_reg.brk && !st_next.brk;

    // Underrun/END_OF_MESSAGE: a set in the same cycle as the reset command wins.
    if (is_async)
      st_next.end_of_message = 1'b1;
    else if (crc_to_shift || cmd_send_abrt)
      st_next.end_of_message = 1'b1;
    else if (cmd_reset_eom)
      st_next.end_of_message = 1'b0;

    // Search state of the receiver in the synchronous modes.
    if (st_reg.mode == esl_pkg::ESL_MODE_SYNC)
    begin
      if (enter_search)
        st_next.search = 1'b1;
      else if (rx_ev.sync_match)
        st_next.search = 1'b0;
    end
    else if (st_reg.mode == esl_pkg::ESL_MODE_SDLC)
    begin
      if (enter_search || (st_next.rx_en && !st_reg.rx_en) || (st_next.brk && !st_reg.brk))
        st_next.search = 1'b1;
      else if (rx_ev.flag_seen)
        st_next.search = 1'b0;
    end
    else
      st_next.search = 1'b0;

    if (baud_zero)
      st_next.zc = 1'b1;
    else if (baud_reload)
      st_next.zc = 1'b0;

    // Reopen on command, but CTS/DCD with an odd count keep the group closed.
    if (cmd_reset_ext && st_reg.closed)
    begin
      if (|parity_diff)
        st_next.lat = raw;
      else
        st_next.closed = 1'b0;
    end
    if (close_ev && !st_next.closed)
    begin
      st_next.closed = 1'b1;
      st_next.lat    = raw;
    end
    else if (st_reg.closed && chg[esl_pkg::SRC_BRK] && st_reg.srcen[esl_pkg::SRC_BRK])
      st_next.lat[esl_pkg::SRC_BRK] = raw[esl_pkg::SRC_BRK];
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_reg           <= '0;
      st_reg.srcen     <= esl_pkg::SRCEN_RST;
      st_reg.mode      <= esl_pkg::ESL_MODE_ASYNC;
      st_reg.end_of_message       <= 1'b1;
      // END_OF_MESSAGE starts set, so its edge history must agree or the latches close straight out of reset.
      st_reg.prev[esl_pkg::SRC_EOM] <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  assign avs_readdata     = st_reg.rdata;
  assign pending_flag     = st_reg.master_en && st_reg.closed;
  assign rx_search        = st_reg.search;
  assign null_char_keep   = st_reg.null_keep;
  assign tx_next_frame_ok = st_reg.end_of_message && st_reg.auto_flag
                            && st_reg.mode == esl_pkg::ESL_MODE_SDLC;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_pending_gate: assert property (pending_flag |-> st_reg.master_en && st_reg.closed)
    else $error("pending flag without master enable or closed latches");
  a_pending_follow: assert property (st_reg.master_en && st_reg.closed |-> pending_flag)
    else $error("pending flag missing while latches closed");
  a_group_close: assert property (!st_reg.closed && close_ev
                                  |=> st_reg.closed && pending_flag == st_reg.master_en)
    else $error("latches did not close on enabled change");
  a_reset_opens: assert property (cmd_reset_ext && st_reg.closed && !(|parity_diff)
                                  && !close_ev |=> !st_reg.closed)
    else $error("reset command did not open the latches");
  a_read_stable: assert property (rd_first && avs_address == esl_pkg::ADDR_STATUS
                                  |=> st_reg.ack && !avs_waitrequest
                                      && avs_readdata[5:0] == $past(status))
    else $error("status read word not frozen at request");
  a_zc_forced: assert property (!st_reg.srcen[esl_pkg::SRC_ZC] |-> !status[esl_pkg::SRC_ZC])
    else $error("zero count visible while disabled");
  a_brk_sync0: assert property (st_reg.mode == esl_pkg::ESL_MODE_SYNC |=> !st_reg.brk)
    else $error("break bit set in plain sync mode");
  a_eom_async: assert property (is_async |=> st_reg.end_of_message)
    else $error("eom clear in async mode");
  a_eom_crc: assert property (crc_to_shift && !is_async |=> st_reg.end_of_message)
    else $error("eom not set on crc load");
  a_xtal_sync0: assert property (sync_forced |-> !raw[esl_pkg::SRC_SYNC])
    else $error("sync bit not forced by crystal");
  a_abort_search: assert property (st_reg.mode == esl_pkg::ESL_MODE_SDLC && $rose(st_next.brk)
                                   |=> st_reg.search)
    else $error("abort did not force search");
  a_brk_recapture: assert property (st_reg.closed && st_reg.srcen[esl_pkg::SRC_BRK]
      && chg[esl_pkg::SRC_BRK]
      |=> st_reg.closed && st_reg.lat[esl_pkg::SRC_BRK] == $past(raw[esl_pkg::SRC_BRK]))
    else $error("break edge not recaptured while latches closed");
  a_parity_hold: assert property (cmd_reset_ext && st_reg.closed && |parity_diff
      |=> st_reg.closed)
    else $error("odd line transitions did not keep latches closed");
  a_eom_clear: assert property (cmd_reset_eom && !is_async && !crc_to_shift
      |=> !st_reg.end_of_message)
    else $error("eom not cleared by its reset command");
  a_zc_live: assert property (baud_zero && st_reg.srcen[esl_pkg::SRC_ZC] && !wr_ack
      |=> status[esl_pkg::SRC_ZC])
    else $error("zero count not shown live");
  a_zc_reload: assert property (baud_reload && !baud_zero |=> !st_reg.zc)
    else $error("zero count not cleared on reload");
  a_brk_async: assert property (is_async && rx_ev.char_valid && rx_ev.null_char
      && rx_ev.framing_err |=> st_reg.brk)
    else $error("break not set on null with framing error");
  a_null_keep: assert property (is_async && st_reg.brk && rx_ev.bit_valid
      && rx_ev.bit_value && !rx_ev.char_valid |=> null_char_keep)
    else $error("no null kept when break ended");
  a_hunt_enter: assert property (st_reg.mode == esl_pkg::ESL_MODE_SYNC && enter_search
      |=> st_reg.search)
    else $error("enter search command ignored");
  a_hunt_leave: assert property (st_reg.mode == esl_pkg::ESL_MODE_SYNC && rx_ev.sync_match
      && !enter_search |=> !st_reg.search)
    else $error("sync match did not leave search");
  a_flag_leave: assert property (st_reg.mode == esl_pkg::ESL_MODE_SDLC && rx_ev.flag_seen
      && !wr_ack && !rx_ev.bit_valid |=> !st_reg.search)
    else $error("received flag did not leave search");

  c_close_reopen: cover property (!st_reg.closed ##1 st_reg.closed ##[1:20] !st_reg.closed);
  c_status_read: cover property (rd_first && avs_address == esl_pkg::ADDR_STATUS && st_reg.closed);
  c_sdlc_abort: cover property (st_reg.mode == esl_pkg::ESL_MODE_SDLC && $rose(st_reg.brk));
  c_odd_parity: cover property (cmd_reset_ext && st_reg.closed && |parity_diff);

endmodule // esl_ext_status

`default_nettype wire

// ---- esl_host_model.sv ----
// Host processor model that runs Avalon-MM register cycles against the latch block.
`timescale 1ns/1ps
`default_nettype none

module esl_host_model (
  // Clock
  input  wire logic        clk_sys,
  // Avalon-MM master
  output logic      [4:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  initial
  begin
    avs_address    <= 5'h00;
    avs_read       <= 1'b0;
    avs_write      <= 1'b0;
    avs_writedata  <= 32'h0000_0000;
    avs_byteenable <= 4'hf;
  end

  // The request stays put until waitrequest is seen low; only the bench timeout ends a stuck wait.
  task automatic access(input logic is_rd, input logic [4:0] a, input logic [31:0] wd,
                        output logic [31:0] d);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_read      <= is_rd;
    avs_write     <= ~is_rd;
    avs_writedata <= wd;
    do
    begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    logic [31:0] d;
    access(1'b0, a, {24'h00_0000, v}, d);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    access(1'b1, a, 32'h0000_0000, d);
  endtask

  // Current values are only guaranteed once the shared latches are reopened.
  task automatic reopen();
    wr(esl_pkg::ADDR_CMD, esl_pkg::CMD_RESET_EXT);
  endtask
endmodule // esl_host_model

`default_nettype wire

// ---- testbench.sv ----
// Self-checking testbench for the external/status interrupt latch.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic                clk_sys  = 1'b0;
  logic                rst      = 1'b1;
  logic [4:0]          avs_address;
  logic                avs_read;
  logic                avs_write;
  logic [31:0]         avs_writedata;
  logic [3:0]          avs_byteenable;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  logic [2:0]          lines    = 3'h0;
  logic [2:0]          strb     = 3'h0;
  esl_pkg::esl_rx_ev_s rx_ev    = '0;
  logic                pending_flag;
  logic                rx_search;
  logic                null_char_keep;
  logic                tx_next_frame_ok;
  int                  fails    = 0;
  int                  compares = 0;
  int                  cycles   = 0;
  int                  keeps    = 0;
  logic [31:0]         rv;

  always #10 clk_sys = ~clk_sys;

  esl_host_model u_host (.clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  esl_ext_status u_dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cts_in(lines[0]), .dcd_in(lines[1]),
    .sync_in(lines[2]), .rx_ev(rx_ev), .crc_to_shift(strb[0]), .baud_zero(strb[1]),
    .baud_reload(strb[2]), .pending_flag(pending_flag), .rx_search(rx_search),
    .null_char_keep(null_char_keep), .tx_next_frame_ok(tx_next_frame_ok));

  // A one-cycle pulse is easy to miss by polling, so every cycle is watched.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (null_char_keep === 1'b1)
      keeps++;
    if (cycles == 6000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic expect_st(input logic [5:0] st, input logic pend);
    u_host.rd(esl_pkg::ADDR_STATUS, rv);
    chk("status", {26'h000_0000, st}, rv);
    chk("pending", {31'h0000_0000, pend}, {31'h0000_0000, pending_flag});
  endtask

  task automatic flag_is(input string what, input logic exp, input logic got);
    chk(what, {31'h0000_0000, exp}, {31'h0000_0000, got});
  endtask

  task automatic put(input logic [4:0] a, input logic [7:0] v);
    u_host.wr(a, v);
    tick(3);
  endtask

  task automatic reopen();
    u_host.reopen();
    tick(3);
  endtask

  task automatic toggle(input int i);
    @(posedge clk_sys);
    lines[i] <= ~lines[i];
    tick(3);
  endtask

  task automatic pulse(input int i);
    @(posedge clk_sys);
    strb[i] <= 1'b1;
    @(posedge clk_sys);
    strb[i] <= 1'b0;
    tick(3);
  endtask

  task automatic ev(input esl_pkg::esl_rx_ev_s e);
    @(posedge clk_sys);
    rx_ev <= e;
    @(posedge clk_sys);
    rx_ev <= '0;
    tick(3);
  endtask

  task automatic rxbit(input logic v);
    ev('{bit_valid: 1'b1, bit_value: v, default: 1'b0});
  endtask

  task automatic t_reset();
    u_host.rd(esl_pkg::ADDR_SRCEN, rv);
    chk("srcen", {26'h000_0000, esl_pkg::SRCEN_RST}, rv);
    u_host.rd(esl_pkg::ADDR_ICTL, rv);
    chk("ictl", 32'h0000_0000, rv);
    u_host.rd(5'h01, rv);
    chk("unmapped", 32'h0000_0000, rv);
    expect_st(6'h10, 1'b0);
  endtask

  task automatic t_latch();
    toggle(0);
    expect_st(6'h18, 1'b0);
    reopen();
    reopen();
    put(esl_pkg::ADDR_ICTL, 8'h01);
    expect_st(6'h18, 1'b0);
    toggle(1);
    expect_st(6'h1A, 1'b1);
    toggle(0);
    expect_st(6'h1A, 1'b1);
    reopen();
    expect_st(6'h12, 1'b1);
    toggle(1);
    toggle(1);
    reopen();
    expect_st(6'h12, 1'b0);
    put(esl_pkg::ADDR_SRCEN, 8'h37);
    toggle(0);
    expect_st(6'h1A, 1'b0);
    put(esl_pkg::ADDR_SRCEN, 8'h3F);
  endtask

  task automatic t_zero();
    pulse(1);
    expect_st(6'h1B, 1'b1);
    pulse(2);
    expect_st(6'h1A, 1'b1);
    reopen();
    expect_st(6'h1A, 1'b0);
    put(esl_pkg::ADDR_SRCEN, 8'h3E);
    pulse(1);
    expect_st(6'h1A, 1'b0);
    pulse(2);
    put(esl_pkg::ADDR_SRCEN, 8'h3F);
  endtask

  task automatic t_eom();
    put(esl_pkg::ADDR_MODE, 8'h01);
    put(esl_pkg::ADDR_CMD, esl_pkg::CMD_RESET_EOM);
    expect_st(6'h0A, 1'b0);
    pulse(0);
    expect_st(6'h1A, 1'b1);
    reopen();
    put(esl_pkg::ADDR_CMD, esl_pkg::CMD_RESET_EOM);
    put(esl_pkg::ADDR_CMD, esl_pkg::CMD_SEND_ABRT);
    expect_st(6'h1A, 1'b1);
    reopen();
    put(esl_pkg::ADDR_MODE, 8'h02);
    put(esl_pkg::ADDR_EXTOPT, 8'h01);
    flag_is("next_frame", 1'b1, tx_next_frame_ok);
  endtask

  task automatic t_abort();
    repeat (6) rxbit(1'b1);
    expect_st(6'h1A, 1'b0);
    rxbit(1'b1);
    expect_st(6'h3E, 1'b1);
    flag_is("search", 1'b1, rx_search);
    rxbit(1'b0);
    expect_st(6'h1E, 1'b1);
    ev('{flag_seen: 1'b1, default: 1'b0});
    flag_is("search", 1'b0, rx_search);
    reopen();
    expect_st(6'h1A, 1'b0);
    put(esl_pkg::ADDR_RXCTL, 8'h01);
    expect_st(6'h1E, 1'b1);
    ev('{flag_seen: 1'b1, default: 1'b0});
    reopen();
    expect_st(6'h1A, 1'b0);
    put(esl_pkg::ADDR_RXCTL, 8'h02);
    u_host.rd(esl_pkg::ADDR_RXCTL, rv);
    chk("rxctl", 32'h0000_0002, rv);
    flag_is("search", 1'b1, rx_search);
    expect_st(6'h1E, 1'b1);
    ev('{flag_seen: 1'b1, default: 1'b0});
    reopen();
  endtask

  task automatic t_hunt();
    put(esl_pkg::ADDR_MODE, 8'h01);
    repeat (7) rxbit(1'b1);
    expect_st(6'h1A, 1'b0);
    put(esl_pkg::ADDR_RXCTL, 8'h01);
    expect_st(6'h1E, 1'b1);
    reopen();
    ev('{sync_match: 1'b1, default: 1'b0});
    expect_st(6'h1A, 1'b1);
    reopen();
  endtask

  task automatic t_break();
    put(esl_pkg::ADDR_MODE, 8'h00);
    expect_st(6'h1A, 1'b0);
    ev('{char_valid: 1'b1, null_char: 1'b1, framing_err: 1'b1, default: 1'b0});
    expect_st(6'h3A, 1'b1);
    rxbit(1'b0);
    rxbit(1'b1);
    expect_st(6'h1A, 1'b1);
    chk("null_keeps", 32'h0000_0001, keeps);
    reopen();
    toggle(2);
    expect_st(6'h1E, 1'b1);
    reopen();
    toggle(2);
    expect_st(6'h1A, 1'b1);
    reopen();
    put(esl_pkg::ADDR_MODE, 8'h04);
    toggle(2);
    expect_st(6'h1A, 1'b0);
    put(esl_pkg::ADDR_MODE, 8'h03);
    expect_st(6'h1E, 1'b1);
    reopen();
    toggle(2);
    expect_st(6'h1A, 1'b1);
    reopen();
    put(esl_pkg::ADDR_MODE, 8'h07);
    toggle(2);
    expect_st(6'h1A, 1'b0);
  endtask

  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_latch();
    t_zero();
    t_eom();
    t_abort();
    t_hunt();
    t_break();
    tally_and_finish();
  end
endmodule // testbench

`default_nettype wire
